// ===== rtl/advanced_sector_guard.sv
// Per-sector program/erase protection with persistent and password lock management
//
// Chosen here: the register offsets and register access over APB.
module advanced_sector_guard
   import guard_pkg::*;
#(
   parameter int NUM_SECTORS = NUM_SECTORS_DEF,
   parameter int UNLOCK_GAP = UNLOCK_GAP_CYCLES,
   parameter int PROG_CYCLES = PROG_TIME_CYCLES,
   parameter int ERASE_CYCLES = ERASE_TIME_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hw_reset_pin_n,
   input wire logic [NUM_SECTORS-1:0] block_protect,
   output logic [NUM_SECTORS-1:0] sector_protected,
   output logic write_in_progress,
   output logic prog_error
);
   localparam int IW = $clog2(NUM_SECTORS);

   typedef struct packed {
      phase_t phase;
      op_t op;
      logic [TIMER_W-1:0] timer;
      logic [IW-1:0] op_sector;
      logic [IW-1:0] sel;
      logic [NUM_SECTORS-1:0] dynamic_sector_bit;
      logic lock;
      logic [1:0] mode;
      logic [PW_W-1:0] password;
      logic [PW_W-1:0] pw_stage;
      logic [1:0] cfg_stage;
      logic match;
      logic p_err;
      logic [31:0] prdata;
   } guard_state_t;

   guard_state_t s_reg, s_next;
   logic hw_n;
   logic mem_wr;
   logic mem_erase;
   logic setup;
   logic access;
   logic addr_ok;
   logic wr_ok;
   logic busy;
   logic pw_mode;
   logic cmd_go;
   op_t cmd_op;

   ppb_if #(.N(NUM_SECTORS), .IW(IW)) pbus ();

   pin_sync #(.W(1), .RST_VAL(1'b1)) u_hw_sync (
      .clk(clk),
      .resetn(resetn),
      .din(hw_reset_pin_n),
      .dout(hw_n)
   );

   ppb_store #(.N(NUM_SECTORS), .IW(IW)) u_ppb (
      .clk(clk),
      .resetn(resetn),
      .bus(pbus)
   );

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign addr_ok = (paddr == OFS_CMD) || (paddr == OFS_STATUS) || (paddr == OFS_CFG) ||
                    (paddr == OFS_PW_LO) || (paddr == OFS_PW_HI) || (paddr == OFS_SEL);
   assign wr_ok = access && pwrite && addr_ok && hw_n;
   assign busy = (s_reg.phase == PH_BUSY);
   assign pw_mode = !s_reg.mode[MODE_PW_BIT];
   assign cmd_op = op_t'(pwdata[CMD_OP_MSB:0]);
   // Commands arriving while busy are dropped; the host polls write_in_progress
   assign cmd_go = wr_ok && (paddr == OFS_CMD) && !busy;

   assign pbus.wr_en = mem_wr;
   assign pbus.wr_idx = s_reg.op_sector;
   assign pbus.erase = mem_erase;
   assign pbus.rd_idx = s_reg.sel;

   always_comb
   begin
      logic [31:0] rd;
      rd = '0;
      s_next = s_reg;
      mem_wr = 1'b0;
      mem_erase = 1'b0;

      unique case (paddr)
         OFS_STATUS:
         begin
            rd[ST_WIP] = busy;
            rd[ST_PERR] = s_reg.p_err;
            rd[ST_LOCK] = s_reg.lock;
            rd[ST_MODE_LSB +: 2] = s_reg.mode;
            rd[ST_PPB] = pbus.rd_bit;
            rd[ST_DYB] = s_reg.dynamic_sector_bit[s_reg.sel];
         end
         OFS_CFG: rd[CFG_MODE_LSB +: 2] = s_reg.mode;
         OFS_PW_LO: rd = pw_mode ? '0 : s_reg.password[31:0];
         OFS_PW_HI: rd = pw_mode ? '0 : s_reg.password[63:32];
         OFS_SEL: rd[IW-1:0] = s_reg.sel;
         default: rd = '0;
      endcase
      if (setup)
         s_next.prdata = rd;

      if (wr_ok && (paddr == OFS_STATUS) && pwdata[ST_PERR])
         s_next.p_err = 1'b0;
      if (wr_ok && (paddr == OFS_SEL))
         s_next.sel = pwdata[IW-1:0];
      // Staging is frozen while an operation runs so it completes on what it started with
      if (wr_ok && !busy && (paddr == OFS_CFG))
         s_next.cfg_stage = pwdata[CFG_MODE_LSB +: 2];
      if (wr_ok && !busy && (paddr == OFS_PW_LO))
         s_next.pw_stage[31:0] = pwdata;
      if (wr_ok && !busy && (paddr == OFS_PW_HI))
         s_next.pw_stage[63:32] = pwdata;

      if (busy)
      begin
         if (s_reg.timer <= TIMER_W'(1))
         begin
            s_next.phase = PH_IDLE;
            s_next.timer = '0;
            unique case (s_reg.op)
               OP_PPB_PROG: mem_wr = 1'b1;
               OP_PPB_ERASE: mem_erase = 1'b1;
               OP_PW_PROG: s_next.password = s_reg.password & s_reg.pw_stage;
               OP_CFG_PROG: s_next.mode = s_reg.mode & s_reg.cfg_stage;
               OP_PW_UNLOCK:
               begin
                  if (s_reg.match)
                     s_next.lock = 1'b1;
               end
               default: ;
            endcase
         end
         else
         begin
            s_next.timer = s_reg.timer - TIMER_W'(1);
         end
      end
      else if (cmd_go)
      begin
         s_next.op = cmd_op;
         s_next.op_sector = s_reg.sel;
         case (cmd_op)
            OP_DYB_WRITE: s_next.dynamic_sector_bit[s_reg.sel] = pwdata[CMD_VALUE_BIT];
            OP_LOCK_CLEAR: s_next.lock = 1'b0;
            OP_SOFT_RESET: s_next.dynamic_sector_bit = '1;
            OP_PPB_PROG, OP_PPB_ERASE:
            begin
               if (!s_reg.lock)
                  s_next.p_err = 1'b1;
               else
               begin
                  s_next.phase = PH_BUSY;
                  s_next.timer = (cmd_op == OP_PPB_ERASE) ? TIMER_W'(ERASE_CYCLES) :
                                 TIMER_W'(PROG_CYCLES);
               end
            end
            OP_PW_PROG:
            begin
               if (!pw_mode)
               begin
                  s_next.phase = PH_BUSY;
                  s_next.timer = TIMER_W'(PROG_CYCLES);
               end
            end
            OP_CFG_PROG:
            begin
               if (s_reg.mode != MODE_UNSEL || s_reg.cfg_stage == MODE_ILLEGAL)
                  s_next.p_err = 1'b1;
               else
               begin
                  s_next.phase = PH_BUSY;
                  s_next.timer = TIMER_W'(PROG_CYCLES);
               end
            end
            OP_PW_UNLOCK:
            begin
               if (pw_mode)
               begin
                  s_next.match = (s_reg.pw_stage == s_reg.password);
                  s_next.phase = PH_BUSY;
                  if (s_reg.pw_stage == s_reg.password)
                     s_next.timer = TIMER_W'(1);
                  else
                  begin
                     s_next.p_err = 1'b1;
                     s_next.timer = TIMER_W'(UNLOCK_GAP);
                  end
               end
            end
            default: ;
         endcase
      end

      // Hardware reset pin: volatile state only, persistent bits and mode survive
      if (!hw_n)
      begin
         s_next.dynamic_sector_bit = '1;
         s_next.lock = !pw_mode;
         s_next.phase = PH_IDLE;
         s_next.timer = '0;
         s_next.p_err = 1'b0;
         // An operation cut short by the pin must not commit its one-time result
         s_next.mode = s_reg.mode;
         s_next.password = s_reg.password;
         mem_wr = 1'b0;
         mem_erase = 1'b0;
      end
   end

   // Power-on reset brings up the factory state
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         s_reg <= '0;
         s_reg.dynamic_sector_bit <= '1;
         s_reg.lock <= 1'b1;
         s_reg.mode <= MODE_UNSEL;
         s_reg.password <= PW_FACTORY;
         s_reg.pw_stage <= PW_FACTORY;
         s_reg.cfg_stage <= MODE_UNSEL;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign sector_protected = block_protect | ~(pbus.bits & s_reg.dynamic_sector_bit);
   assign prdata = s_reg.prdata;
   assign pready = 1'b1;
   assign pslverr = access && !addr_ok;
   assign write_in_progress = busy;
   assign prog_error = s_reg.p_err;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_unlock_bad;
      cmd_go && (cmd_op == OP_PW_UNLOCK) && pw_mode && hw_n &&
      (s_reg.pw_stage != s_reg.password);
   endsequence
   sequence s_unlock_good;
      cmd_go && (cmd_op == OP_PW_UNLOCK) && pw_mode && hw_n &&
      (s_reg.pw_stage == s_reg.password);
   endsequence

   property p_illegal_mode;
      cmd_go && hw_n && (cmd_op == OP_CFG_PROG) && (s_reg.cfg_stage == MODE_ILLEGAL)
      |=> prog_error && !write_in_progress && (s_reg.mode == $past(s_reg.mode));
   endproperty
   a_illegal_mode: assert property (p_illegal_mode) else $error("mode 00 accepted");

   property p_mode_frozen;
      (s_reg.mode != MODE_UNSEL) |=> (s_reg.mode == $past(s_reg.mode));
   endproperty
   a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed");

   property p_cfg_busy;
      cmd_go && hw_n && (cmd_op == OP_CFG_PROG) && (s_reg.mode == MODE_UNSEL) &&
      (s_reg.cfg_stage != MODE_ILLEGAL) |=> write_in_progress[*8];
   endproperty
   a_cfg_busy: assert property (p_cfg_busy) else $error("config program not busy");

   property p_ppb_locked;
      cmd_go && hw_n && !s_reg.lock && (cmd_op inside {OP_PPB_PROG, OP_PPB_ERASE})
      |=> prog_error && !write_in_progress && $stable(pbus.bits);
   endproperty
   a_ppb_locked: assert property (p_ppb_locked) else $error("locked ppb changed");

   property p_ppb_blocks;
      (~pbus.bits & ~sector_protected) == '0;
   endproperty
   a_ppb_blocks: assert property (p_ppb_blocks) else $error("ppb zero not protected");

   property p_dyb_protect;
      logic [IW-1:0] idx;
      (cmd_go && hw_n && (cmd_op == OP_DYB_WRITE) && !pwdata[CMD_VALUE_BIT], idx = s_reg.sel)
      |=> sector_protected[idx];
   endproperty
   a_dyb_protect: assert property (p_dyb_protect) else $error("dyb clear ignored");

   property p_soft_reset;
      cmd_go && hw_n && (cmd_op == OP_SOFT_RESET)
      |=> (&s_reg.dynamic_sector_bit) && (s_reg.lock == $past(s_reg.lock));
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

   property p_hw_lock;
      !hw_n |=> (s_reg.lock == !pw_mode) && (&s_reg.dynamic_sector_bit) && !write_in_progress;
   endproperty
   a_hw_lock: assert property (p_hw_lock) else $error("hardware reset lock wrong");

   property p_unlock_bad;
      s_unlock_bad |=> (prog_error && write_in_progress && !s_reg.lock)[*8];
   endproperty
   a_unlock_bad: assert property (p_unlock_bad) else $error("mismatch handling wrong");

   property p_unlock_good;
      s_unlock_good ##1 hw_n |=> !write_in_progress && s_reg.lock;
   endproperty
   a_unlock_good: assert property (p_unlock_good) else $error("good unlock delayed");

   property p_pw_only_clears;
      hw_n |=> ((s_reg.password & ~$past(s_reg.password)) == '0);
   endproperty
   a_pw_only_clears: assert property (p_pw_only_clears) else $error("password bit set");

   property p_pw_hidden;
      setup && pw_mode && ((paddr == OFS_PW_LO) || (paddr == OFS_PW_HI)) |=> (prdata == '0);
   endproperty
   a_pw_hidden: assert property (p_pw_hidden) else $error("password readable");

   property p_lock_clear;
      cmd_go && (cmd_op == OP_LOCK_CLEAR) && hw_n |=> !s_reg.lock;
   endproperty
   a_lock_clear: assert property (p_lock_clear) else $error("lock not cleared");
endmodule : advanced_sector_guard

// ===== rtl/guard_pkg.sv
// Constants, register map and enumerations of the sector protection block
package guard_pkg;
   localparam int CLK_FREQ_MHZ = 100;
   localparam int UNLOCK_GAP_US = 100;
   localparam int UNLOCK_GAP_CYCLES = UNLOCK_GAP_US * CLK_FREQ_MHZ;
   localparam int PROG_TIME_CYCLES = 64;
   localparam int ERASE_TIME_CYCLES = 256;
   localparam int TIMER_W = 16;
   localparam int PW_W = 64;
   localparam int NUM_SECTORS_DEF = 64;

   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;
   localparam logic [7:0] OFS_PW_LO = 8'h0C;
   localparam logic [7:0] OFS_PW_HI = 8'h10;
   localparam logic [7:0] OFS_SEL = 8'h14;

   localparam int CMD_OP_MSB = 3;
   localparam int CMD_VALUE_BIT = 8;
   localparam int ST_WIP = 0;
   localparam int ST_PERR = 1;
   localparam int ST_LOCK = 2;
   localparam int ST_MODE_LSB = 3;
   localparam int ST_PPB = 5;
   localparam int ST_DYB = 6;
   localparam int CFG_MODE_LSB = 1;

   localparam logic [1:0] MODE_UNSEL = 2'h3;
   localparam logic [1:0] MODE_ILLEGAL = 2'h0;
   localparam int MODE_PW_BIT = 1;
   localparam logic [PW_W-1:0] PW_FACTORY = 64'hFFFF_FFFF_FFFF_FFFF;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_PPB_PROG = 4'h1,
      OP_PPB_ERASE = 4'h2,
      OP_DYB_WRITE = 4'h3,
      OP_LOCK_CLEAR = 4'h4,
      OP_PW_PROG = 4'h5,
      OP_PW_UNLOCK = 4'h6,
      OP_CFG_PROG = 4'h7,
      OP_SOFT_RESET = 4'h8
   } op_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_BUSY = 2'h1
   } phase_t;
endpackage : guard_pkg

// ===== rtl/pin_sync.sv
// Two flip-flop synchroniser for pin inputs
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t r_reg, r_next;

   always_comb
   begin
      r_next.s1 = din;
      r_next.s2 = r_reg.s1;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         r_reg.s1 <= RST_VAL;
         r_reg.s2 <= RST_VAL;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign dout = r_reg.s2;
endmodule : pin_sync

// ===== rtl/ppb_if.sv
// Link between the protection control and the persistent bit store
interface ppb_if #(parameter int N = 64, parameter int IW = 6);
   logic wr_en;
   logic [IW-1:0] wr_idx;
   logic erase;
   logic [IW-1:0] rd_idx;
   logic rd_bit;
   logic [N-1:0] bits;
   modport ctrl (output wr_en, wr_idx, erase, rd_idx, input rd_bit, bits);
   modport store (input wr_en, wr_idx, erase, rd_idx, output rd_bit, bits);
endinterface : ppb_if

// ===== rtl/ppb_store.sv
// Non-volatile persistent sector bits, one per sector
module ppb_store #(
   parameter int N = 64,
   parameter int IW = 6
) (
   input wire logic clk,
   input wire logic resetn,
   ppb_if.store bus
);
   typedef struct packed {
      logic [N-1:0] bits;
      logic rd_bit;
   } store_t;
   store_t r_reg, r_next;

   always_comb
   begin
      r_next = r_reg;
      if (bus.erase)
         r_next.bits = '1;
      else if (bus.wr_en)
         r_next.bits[bus.wr_idx] = 1'b0;
      r_next.rd_bit = r_reg.bits[bus.rd_idx];
   end

   // Only the power-on reset reaches these bits: they model the factory state
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         r_reg.bits <= '1;
         r_reg.rd_bit <= 1'b1;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign bus.bits = r_reg.bits;
   assign bus.rd_bit = r_reg.rd_bit;
endmodule : ppb_store

// ===== test/apb_host_model.sv
// Register bus host that issues transfers to the protection block
module apb_host_model
(
   input wire logic clk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic [7:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_err;
   initial
   begin
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0;
      last_err = 1'b0;
   end
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines show inverted values so nothing stale looks valid
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : apb_host_model

// ===== test/test_advanced_sector_guard.sv
// Self-checking bench for the sector protection block
module test_advanced_sector_guard
   import guard_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int NS = 8;
   localparam int GAP = 20;
   localparam int PROG = 10;
   localparam int ERASE = 12;
   logic clk = 1'b0;
   logic resetn, hw_reset_pin_n, psel, penable, pwrite, pready, pslverr;
   logic write_in_progress, prog_error, m_lock, m_perr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, q2;
   logic [NS-1:0] block_protect, sector_protected, m_ppb, m_dyb;
   logic [1:0] m_mode;
   logic [63:0] m_pw, pa;
   int err_count, tests_run, n, i, m_sel;

   always #5 clk = ~clk;

   advanced_sector_guard #(.NUM_SECTORS(NS), .UNLOCK_GAP(GAP), .PROG_CYCLES(PROG),
      .ERASE_CYCLES(ERASE)) dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hw_reset_pin_n(hw_reset_pin_n), .block_protect(block_protect),
      .sector_protected(sector_protected), .write_in_progress(write_in_progress),
      .prog_error(prog_error));

   apb_host_model host (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));

   task finish_test();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q2);
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] d);
      host.xfer(1'b0, a, 32'h0, d);
   endtask : rd

   task cmd(input op_t op, input logic v);
      wr(OFS_CMD, {23'h0, v, 4'h0, op});
   endtask : cmd

   task sel(input int s);
      wr(OFS_SEL, 32'(s));
      m_sel = s;
   endtask : sel

   task stage_pw(input logic [63:0] p);
      wr(OFS_PW_LO, p[31:0]);
      wr(OFS_PW_HI, p[63:32]);
   endtask : stage_pw

   // Bounded so a stuck busy flag ends as a mismatch, not a hang
   task wait_idle(output int c);
      c = 0;
      @(posedge clk);
      while (write_in_progress === 1'b1 && c < 5000)
      begin
         @(posedge clk);
         c++;
      end
   endtask : wait_idle

   task clr_perr();
      wr(OFS_STATUS, 32'h0000_0002);
      m_perr = 1'b0;
   endtask : clr_perr

   task hw_rst();
      @(posedge clk);
      hw_reset_pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      hw_reset_pin_n <= 1'b1;
      repeat (5) @(posedge clk);
      m_dyb = '1;
      m_perr = 1'b0;
      m_lock = (m_mode == 2'b01) ? 1'b0 : 1'b1;
   endtask : hw_rst

   task check_all();
      @(posedge clk);
      block_protect <= NS'($urandom);
      rd(OFS_STATUS, q);
      chk("wip", 1'b0, q[ST_WIP]);
      chk("wip_pin", 1'b0, write_in_progress);
      chk("perr", m_perr, q[ST_PERR]);
      chk("perr_pin", m_perr, prog_error);
      chk("lock", m_lock, q[ST_LOCK]);
      chk("mode", m_mode, q[ST_MODE_LSB +: 2]);
      chk("ppb_sel", m_ppb[m_sel], q[ST_PPB]);
      chk("dyb_sel", m_dyb[m_sel], q[ST_DYB]);
      chk("protected", NS'(block_protect | ~(m_ppb & m_dyb)), sector_protected);
   endtask : check_all

   task chk_pw();
      rd(OFS_PW_LO, q);
      rd(OFS_PW_HI, q2);
      chk("password", m_pw, {q2, q});
   endtask : chk_pw

   initial
   begin
      repeat (30000) @(posedge clk);
      err_count++;
      finish_test();
   end

   initial
   begin
      void'($urandom(32'hDD9E58DF));
      resetn = 1'b0;
      hw_reset_pin_n = 1'b1;
      block_protect = '0;
      m_ppb = '1;
      m_dyb = '1;
      m_lock = 1'b1;
      m_perr = 1'b0;
      m_mode = 2'b11;
      m_pw = PW_FACTORY;
      m_sel = 0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      check_all();
      chk_pw();
      rd(8'h40, q);
      chk("slverr", 1'b1, host.last_err);
      chk("pready", 1'b1, pready);
      for (i = 0; i < 2 * NS; i++)
      begin
         sel(i % NS);
         n = $urandom % 2;
         cmd(OP_DYB_WRITE, n[0]);
         m_dyb[i % NS] = n[0];
         check_all();
      end
      sel(5);
      cmd(OP_PPB_PROG, 1'b0);
      wait_idle(n);
      chk("prog_time", 1'b1, n >= PROG - 3 && n <= PROG + 2);
      m_ppb[5] = 1'b0;
      check_all();
      cmd(OP_PPB_ERASE, 1'b0);
      wait_idle(n);
      chk("erase_time", 1'b1, n >= ERASE - 3 && n <= ERASE + 2);
      m_ppb = '1;
      check_all();
      sel(3);
      cmd(OP_PPB_PROG, 1'b0);
      wait_idle(n);
      m_ppb[3] = 1'b0;
      cmd(OP_LOCK_CLEAR, 1'b0);
      m_lock = 1'b0;
      check_all();
      cmd(OP_PPB_ERASE, 1'b0);
      m_perr = 1'b1;
      check_all();
      clr_perr();
      sel(1);
      cmd(OP_DYB_WRITE, 1'b0);
      m_dyb[1] = 1'b0;
      check_all();
      cmd(OP_SOFT_RESET, 1'b0);
      m_dyb = '1;
      check_all();
      cmd(OP_DYB_WRITE, 1'b0);
      m_dyb[1] = 1'b0;
      hw_rst();
      check_all();
      wr(OFS_CFG, 32'h0);
      cmd(OP_CFG_PROG, 1'b0);
      m_perr = 1'b1;
      check_all();
      clr_perr();
      // Password goes in before the mode bits are committed
      pa = {$urandom, $urandom};
      stage_pw(pa);
      cmd(OP_PW_PROG, 1'b0);
      wait_idle(n);
      m_pw = pa;
      pa = {$urandom, $urandom};
      stage_pw(pa);
      cmd(OP_PW_PROG, 1'b0);
      wait_idle(n);
      m_pw = m_pw & pa;
      chk_pw();
      check_all();
      wr(OFS_CFG, 32'h0000_0002);
      cmd(OP_CFG_PROG, 1'b0);
      wait_idle(n);
      chk("cfg_time", 1'b1, n >= PROG - 3 && n <= PROG + 2);
      m_mode = 2'b01;
      check_all();
      wr(OFS_CFG, 32'h0000_0004);
      cmd(OP_CFG_PROG, 1'b0);
      m_perr = 1'b1;
      check_all();
      rd(OFS_CFG, q);
      chk("cfg", 2'b01, q[2:1]);
      clr_perr();
      rd(OFS_PW_LO, q);
      chk("pw_hidden", 32'h0, q);
      stage_pw(64'h0);
      cmd(OP_PW_PROG, 1'b0);
      check_all();
      hw_rst();
      check_all();
      stage_pw(~m_pw);
      cmd(OP_PW_UNLOCK, 1'b0);
      rd(OFS_STATUS, q);
      chk("busy", 1'b1, q[ST_WIP]);
      wait_idle(n);
      chk("gap", 1'b1, n >= GAP - 6 && n <= GAP + 2);
      m_perr = 1'b1;
      check_all();
      clr_perr();
      stage_pw(m_pw);
      cmd(OP_PW_UNLOCK, 1'b0);
      wait_idle(n);
      chk("fast", 1'b1, n <= 2);
      m_lock = 1'b1;
      check_all();
      // Second power-on reset: mode bits and persistent bits return to factory state
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      m_ppb = '1;
      m_dyb = '1;
      m_mode = 2'b11;
      m_pw = PW_FACTORY;
      m_sel = 0;
      check_all();
      wr(OFS_CFG, 32'h0000_0004);
      cmd(OP_CFG_PROG, 1'b0);
      wait_idle(n);
      m_mode = 2'b10;
      cmd(OP_LOCK_CLEAR, 1'b0);
      // Staging still equals the factory password, so a wrongly accepted unlock sets lock
      cmd(OP_PW_UNLOCK, 1'b0);
      m_lock = 1'b0;
      check_all();
      chk_pw();
      finish_test();
   end
endmodule : test_advanced_sector_guard
